// ==== rtl/ocd_top.v ====
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "ocd_map.vh"

module ocd_top #(
    parameter CW          = 16,
    parameter TDW         = 20,
    parameter TICK_CYCLES = `OCD_TICK_CYC
) (
    // Clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // AXI4-Lite write address
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // Drive controller
    input  wire [CW-1:0] output_current,
    input  wire          drive_running,
    input  wire          drive_start,
    input  wire          fault_reset,
    // Detection results
    output reg           overcurrent_flag,
    output reg           zero_current_flag,
    output reg           overcurrent_trip_fault,
    output reg           terminal_a_out,
    output reg           terminal_b_out,
    output reg           irq
);

    localparam integer   TICK_M1   = TICK_CYCLES - 1;
    localparam [TDW-1:0] TICK_LAST = TICK_M1[TDW-1:0];
    // Settings and interrupt status.
    reg [CW-1:0] overcurrent_level_r;
    reg [15:0]   overcurrent_delay_r;
    reg [15:0]   overcurrent_hold_time_r;
    reg          overcurrent_trip_select_r;
    reg [CW-1:0] zero_current_level_r;
    reg [15:0]   zero_current_delay_r;
    reg [7:0]    terminal_a_function_select_r;
    reg [7:0]    terminal_b_function_select_r;
    reg [2:0]    irq_stat_r;
    reg [2:0]    irq_mask_r;

    // Bus state.
    reg          aw_full_r;
    reg [7:0]    aw_addr_r;
    reg          w_full_r;
    reg [31:0]   w_data_r;
    reg [3:0]    w_strb_r;

    // Detection state.
    reg [TDW-1:0] div_r;
    reg           tick_r;
    reg [15:0]    hold_cnt_r;
    reg           trip_sel_eff_r;
    reg           oc_flag_nxt;
    reg           trip_nxt;
    reg [2:0]     irq_stat_nxt;

    wire          oc_qual;
    wire          zc_qual;

    // Byte-lane merge of a 16-bit setting.
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16 = old;
            if (strb[0])
                merge16[7:0] = data[7:0];
            if (strb[1])
                merge16[15:8] = data[15:8];
        end
    endfunction

    // Terminal level for a function code.
    function term_map;
        input [7:0] code;
        input       oc;
        input       zc;
        begin
            if (code == `OCD_FN_OC_POS)
                term_map = oc;
            else if (code == `OCD_FN_OC_NEG)
                term_map = ~oc;
            else if (code == `OCD_FN_ZC_POS)
                term_map = zc;
            else if (code == `OCD_FN_ZC_NEG)
                term_map = ~zc;
            else
                term_map = 1'b0;
        end
    endfunction

    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a[1:0] == 2'b00) && (a <= `OCD_IRQ_MASK);
        end
    endfunction

    // Fixed tick shared by every timer.
    always @(posedge aclk)
    begin
        if (!aresetn || div_r == TICK_LAST)
            div_r <= {TDW{1'b0}};
        else
            div_r <= div_r + {{(TDW-1){1'b0}}, 1'b1};
        tick_r <= aresetn && (div_r == TICK_LAST);
    end
    wire oc_cond = drive_running
                && (output_current > overcurrent_level_r);
    // A zero level switches detection off rather than never matching.
    wire zc_cond = drive_running
                && (zero_current_level_r != {CW{1'b0}})
                && (output_current < zero_current_level_r);

    ocd_qual_timer #(.W(16)) u_oc_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick_r),
        .cond      (oc_cond),
        .delay     (overcurrent_delay_r),
        .qualified (oc_qual)
    );

    ocd_qual_timer #(.W(16)) u_zc_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick_r),
        .cond      (zc_cond),
        .delay     (zero_current_delay_r),
        .qualified (zc_qual)
    );

    wire latch_mode = (overcurrent_hold_time_r == `OCD_HOLD_LATCH);
    wire hold_done  = (hold_cnt_r >= overcurrent_hold_time_r);
    always @*
    begin
        oc_flag_nxt = overcurrent_flag;
        if (!overcurrent_flag)
            oc_flag_nxt = oc_qual;
        else if (latch_mode)
        begin
            // A tripped drive needs a fault reset; otherwise a start.
            if (overcurrent_trip_fault ? fault_reset : drive_start)
                oc_flag_nxt = 1'b0;
        end
        else if (!oc_qual && hold_done)
            oc_flag_nxt = 1'b0;
    end

    wire oc_rise = oc_flag_nxt && !overcurrent_flag;
    wire zc_rise = zc_qual && !zero_current_flag;
    always @*
    begin
        trip_nxt = overcurrent_trip_fault;
        if (fault_reset)
            trip_nxt = 1'b0;
        if (oc_rise && trip_sel_eff_r)
            trip_nxt = 1'b1;
    end

    wire trip_rise = trip_nxt && !overcurrent_trip_fault;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            overcurrent_flag       <= 1'b0;
            irq_stat_r             <= 3'b000;
            irq                    <= 1'b0;
            zero_current_flag      <= 1'b0;
            overcurrent_trip_fault <= 1'b0;
            hold_cnt_r             <= 16'h0000;
            trip_sel_eff_r         <= 1'b0;
            terminal_a_out         <= 1'b0;
            terminal_b_out         <= 1'b0;
        end
        else
        begin
            overcurrent_flag       <= oc_flag_nxt;
            zero_current_flag      <= zc_qual;
            overcurrent_trip_fault <= trip_nxt;
            irq_stat_r             <= irq_stat_nxt;
            irq                    <= |(irq_stat_nxt & irq_mask_r);
            if (oc_rise)
                hold_cnt_r <= 16'h0000;
            else if (overcurrent_flag && tick_r && !hold_done)
                hold_cnt_r <= hold_cnt_r + 16'h0001;
            // A new selection is taken only while the flag is off.
            if (!overcurrent_flag && !oc_flag_nxt)
                trip_sel_eff_r <= overcurrent_trip_select_r;
            terminal_a_out <= term_map(terminal_a_function_select_r,
                overcurrent_flag, zero_current_flag);
            terminal_b_out <= term_map(terminal_b_function_select_r,
                overcurrent_flag, zero_current_flag);
        end
    end

    // Write channel: address and data may arrive in either order.
    wire wr_go       = aw_full_r && w_full_r && !s_axi_bvalid;
    wire wr_ok       = addr_ok(aw_addr_r);
    wire wr_irq_stat = wr_go && (aw_addr_r == `OCD_IRQ_STAT)
                    && w_strb_r[0];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r     <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_full_r      <= 1'b0;
            w_data_r      <= 32'h00000000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end
        else
        begin
            s_axi_awready <= !aw_full_r && !s_axi_awready;
            s_axi_wready  <= !w_full_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            overcurrent_level_r          <= `OCD_OC_LEVEL_RST;
            overcurrent_delay_r          <= `OCD_OC_DELAY_RST;
            overcurrent_hold_time_r      <= `OCD_OC_HOLD_RST;
            overcurrent_trip_select_r    <= 1'b0;
            zero_current_level_r         <= `OCD_ZC_LEVEL_RST;
            zero_current_delay_r         <= `OCD_ZC_DELAY_RST;
            terminal_a_function_select_r <= `OCD_TERM_FUNC_RST;
            terminal_b_function_select_r <= `OCD_TERM_FUNC_RST;
            irq_mask_r                   <= 3'b000;
        end
        else if (wr_go)
        begin
            if (aw_addr_r == `OCD_OC_LEVEL)
                overcurrent_level_r <= merge16(overcurrent_level_r,
                    w_data_r, w_strb_r);
            else if (aw_addr_r == `OCD_OC_DELAY)
                overcurrent_delay_r <= merge16(overcurrent_delay_r,
                    w_data_r, w_strb_r);
            else if (aw_addr_r == `OCD_OC_HOLD)
                overcurrent_hold_time_r <= merge16(
                    overcurrent_hold_time_r, w_data_r, w_strb_r);
            else if (aw_addr_r == `OCD_OC_TRIP_SEL && w_strb_r[0])
                overcurrent_trip_select_r <= w_data_r[0];
            else if (aw_addr_r == `OCD_ZC_LEVEL)
                zero_current_level_r <= merge16(zero_current_level_r,
                    w_data_r, w_strb_r);
            else if (aw_addr_r == `OCD_ZC_DELAY)
                zero_current_delay_r <= merge16(zero_current_delay_r,
                    w_data_r, w_strb_r);
            else if (aw_addr_r == `OCD_TERM_A_FUNC && w_strb_r[0])
                terminal_a_function_select_r <= w_data_r[7:0];
            else if (aw_addr_r == `OCD_TERM_B_FUNC && w_strb_r[0])
                terminal_b_function_select_r <= w_data_r[7:0];
            else if (aw_addr_r == `OCD_IRQ_MASK && w_strb_r[0])
                irq_mask_r <= w_data_r[2:0];
        end
    end

    // Sticky events; a new event wins over a write-one clear.
    always @*
    begin
        irq_stat_nxt = irq_stat_r;
        if (wr_irq_stat)
            irq_stat_nxt = irq_stat_r & ~w_data_r[2:0];
        irq_stat_nxt = irq_stat_nxt | {trip_rise, zc_rise, oc_rise};
    end

    // Read channel: one outstanding read, answered the cycle after.
    wire rd_go = s_axi_arvalid && s_axi_arready;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
                s_axi_rdata  <= 32'h00000000;
                if (s_axi_araddr == `OCD_OC_LEVEL)
                    s_axi_rdata <= {{(32-CW){1'b0}}, overcurrent_level_r};
                else if (s_axi_araddr == `OCD_OC_DELAY)
                    s_axi_rdata <= {16'h0000, overcurrent_delay_r};
                else if (s_axi_araddr == `OCD_OC_HOLD)
                    s_axi_rdata <= {16'h0000, overcurrent_hold_time_r};
                else if (s_axi_araddr == `OCD_OC_TRIP_SEL)
                    s_axi_rdata <= {31'h0, overcurrent_trip_select_r};
                else if (s_axi_araddr == `OCD_ZC_LEVEL)
                    s_axi_rdata <= {{(32-CW){1'b0}}, zero_current_level_r};
                else if (s_axi_araddr == `OCD_ZC_DELAY)
                    s_axi_rdata <= {16'h0000, zero_current_delay_r};
                else if (s_axi_araddr == `OCD_TERM_A_FUNC)
                    s_axi_rdata <= {24'h0, terminal_a_function_select_r};
                else if (s_axi_araddr == `OCD_TERM_B_FUNC)
                    s_axi_rdata <= {24'h0, terminal_b_function_select_r};
                else if (s_axi_araddr == `OCD_STATUS)
                    s_axi_rdata <= {28'h0, trip_sel_eff_r,
                        overcurrent_trip_fault, zero_current_flag,
                        overcurrent_flag};
                else if (s_axi_araddr == `OCD_IRQ_STAT)
                    s_axi_rdata <= {29'h0, irq_stat_r};
                else if (s_axi_araddr == `OCD_IRQ_MASK)
                    s_axi_rdata <= {29'h0, irq_mask_r};
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== shared/ocd_map.vh ====
`ifndef OCD_MAP_VH
`define OCD_MAP_VH

// Timing: one tick is 10 ms; times are set in ticks.
`define OCD_CLK_HZ          50000000
`define OCD_TICK_MS         10
`define OCD_TICK_CYC        ((`OCD_CLK_HZ / 1000) * `OCD_TICK_MS)
`define OCD_HOLD_LATCH      16'd9999

// Register byte offsets.
`define OCD_OC_LEVEL        8'h00
`define OCD_OC_DELAY        8'h04
`define OCD_OC_HOLD         8'h08
`define OCD_OC_TRIP_SEL     8'h0c
`define OCD_ZC_LEVEL        8'h10
`define OCD_ZC_DELAY        8'h14
`define OCD_TERM_A_FUNC     8'h18
`define OCD_TERM_B_FUNC     8'h1c
`define OCD_STATUS          8'h20
`define OCD_IRQ_STAT        8'h24
`define OCD_IRQ_MASK        8'h28

// Reset values.
`define OCD_OC_LEVEL_RST    16'h0096
`define OCD_OC_DELAY_RST    16'h0000
`define OCD_OC_HOLD_RST     16'h000a
`define OCD_ZC_LEVEL_RST    16'h0005
`define OCD_ZC_DELAY_RST    16'h0032
`define OCD_TERM_FUNC_RST   8'h00

// Status and interrupt bit positions.
`define OCD_BIT_OC          0
`define OCD_BIT_ZC          1
`define OCD_BIT_TRIP        2
`define OCD_BIT_TSEL        3

// Terminal function codes.
`define OCD_FN_OC_POS       8'd12
`define OCD_FN_OC_NEG       8'd112
`define OCD_FN_ZC_POS       8'd13
`define OCD_FN_ZC_NEG       8'd113

`endif

// ==== rtl/ocd_qual_timer.v ====
`timescale 1ns/1ns
`default_nettype none

module ocd_qual_timer #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Qualification
    input  wire         tick,
    input  wire         cond,
    input  wire [W-1:0] delay,
    output reg          qualified
);

    reg [W-1:0] cnt_r;

    // A lapse of the condition drops the count to zero, so only an
    // unbroken stretch can qualify.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r     <= {W{1'b0}};
            qualified <= 1'b0;
        end
        else if (!cond)
        begin
            cnt_r     <= {W{1'b0}};
            qualified <= 1'b0;
        end
        else if (tick && !qualified)
        begin
            if (cnt_r >= delay)
                qualified <= 1'b1;
            else
                cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// ==== sim/ocd_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module ocd_top_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive side
    input wire logic drive_running,
    input wire logic fault_reset,
    // Detection results
    input wire logic overcurrent_flag,
    input wire logic zero_current_flag,
    input wire logic overcurrent_trip_fault
);
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Two edges back covers the qualifier stage and the flag register.
    AST_OC_RUN: assert property
        ($rose(overcurrent_flag) |-> $past(drive_running, 2))
        else $error("over-current flag rose while stopped");
    AST_ZC_RUN: assert property
        ($rose(zero_current_flag) |-> $past(drive_running, 2))
        else $error("zero-current flag rose while stopped");
    AST_ZC_STOP: assert property
        (!drive_running |-> ##2 !zero_current_flag)
        else $error("zero-current flag stayed on while stopped");
    AST_TRIP_ON_FLAG: assert property
        ($rose(overcurrent_trip_fault) |-> $rose(overcurrent_flag))
        else $error("trip rose apart from the flag");
    AST_TRIP_HOLD: assert property
        (overcurrent_trip_fault && !fault_reset |=> overcurrent_trip_fault)
        else $error("trip dropped without a fault reset");
    AST_TRIP_CLEAR: assert property
        (fault_reset |=> !overcurrent_trip_fault
                         || $rose(overcurrent_trip_fault))
        else $error("fault reset did not clear the trip");
    AST_B_HOLD: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    cover property ($rose(overcurrent_flag));
    cover property ($rose(zero_current_flag));
    cover property ($rose(overcurrent_trip_fault));
endmodule
bind ocd_top ocd_top_assertions u_ocd_top_assertions (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .drive_running, .fault_reset, .overcurrent_flag,
    .zero_current_flag, .overcurrent_trip_fault
);
`default_nettype wire

// ==== sim/ocd_drive_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ocd_drive_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Bench commands
    input  wire logic        cmd_run,
    input  wire logic [15:0] cmd_current,
    input  wire logic        cmd_fault_reset,
    // Trip request
    input  wire logic        overcurrent_trip_fault,
    // Drive side
    output var  logic [15:0] output_current,
    output var  logic        drive_running,
    output var  logic        drive_start,
    output var  logic        fault_reset
);
    // A tripped stage stops the motor, so the measured current collapses
    // and no restart is seen until the trip has been cleared.
    wire run_nxt = cmd_run & ~overcurrent_trip_fault;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            output_current <= 16'h0;
            drive_running  <= 1'b0;
            drive_start    <= 1'b0;
            fault_reset    <= 1'b0;
        end
        else
        begin
            output_current <= run_nxt ? cmd_current : 16'h0;
            drive_running  <= run_nxt;
            drive_start    <= run_nxt & ~drive_running;
            fault_reset    <= cmd_fault_reset;
        end
    end
endmodule
`default_nettype wire

// ==== sim/ocd_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module ocd_top_tb;
    localparam int TK = 10;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        cmd_run = 1'b0;
    logic        cmd_fault_reset = 1'b0;
    logic [15:0] cmd_current = 16'h0;
    logic [15:0] hi;
    wire  [15:0] output_current;
    wire         drive_running, drive_start, fault_reset, irq;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, overcurrent_flag, zero_current_flag;
    wire         overcurrent_trip_fault, terminal_a_out, terminal_b_out;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [5:0]  fl = {overcurrent_trip_fault, irq, terminal_b_out,
                       terminal_a_out, zero_current_flag, overcurrent_flag};
    int          fails = 0;
    int          n_tests = 0;
    int          i, n;
    logic [33:0] exp_q [$];
    logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                            8'h18, 8'h1c, 8'h28};
    logic [31:0] rv [9] = '{32'h96, 32'h0, 32'ha, 32'h0, 32'h5, 32'h32,
                            32'h0, 32'h0, 32'h0};
    logic [31:0] cv [9] = '{32'h64, 32'h3, 32'h5, 32'h0, 32'h5, 32'h2,
                            32'hc, 32'h71, 32'h7};
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    ocd_top #(.TICK_CYCLES(TK)) u_ocd_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .output_current, .drive_running,
        .drive_start, .fault_reset, .overcurrent_flag, .zero_current_flag,
        .overcurrent_trip_fault, .terminal_a_out, .terminal_b_out, .irq
    );
    ocd_drive_model u_ocd_drive_model (
        .aclk, .aresetn, .cmd_run, .cmd_current, .cmd_fault_reset,
        .overcurrent_trip_fault, .output_current, .drive_running,
        .drive_start, .fault_reset
    );
    task automatic end_of_test();
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic [33:0] pop();
        if (exp_q.size() == 0)
            return '1;
        return exp_q.pop_front();
    endfunction
    // Responses are judged where they appear, against the oldest note.
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, pop());
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, pop());
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        int k;
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (k = 0; k < 200; k++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (k == 200)
        begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 34'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {2'b00, e});
    endtask
    task automatic wait_fl(input int b, input logic v, input int lim,
                           output int k);
        k = 0;
        do
        begin
            @(negedge aclk);
            k++;
        end
        while (fl[b] !== v && k < lim);
        if (fl[b] !== v)
        begin
            fails++;
            end_of_test();
        end
        @(posedge aclk);
    endtask
    initial
    begin
        void'($urandom(61));
        hi = 16'd101 + 16'($urandom % 900);
        cyc(4);
        aresetn <= 1'b1;
        for (i = 0; i < 9; i++)
            rd(ra[i], rv[i]);
        bus(1'b0, 8'h2c, 32'h0, {2'b10, 32'h0});
        bus(1'b1, 8'h30, 32'h1, {2'b10, 32'h0});
        wr(8'h20, 32'hf);
        for (i = 0; i < 9; i++)
            wr(ra[i], cv[i]);
        for (i = 0; i < 9; i++)
            rd(ra[i], cv[i]);
        rd(8'h20, 32'h0);
        cmd_run <= 1'b1;
        cmd_current <= 16'd50;
        cyc(3 * TK);
        // A short excursion with a dip must not reach the delay.
        cmd_current <= hi;
        cyc(2 * TK);
        cmd_current <= 16'd50;
        cyc(5);
        cmd_current <= hi;
        wait_fl(0, 1'b1, 6 * TK, n);
        check(n >= 3 * TK, 1);
        cyc(2);
        check(fl[5:2], 4'b0111);
        rd(8'h20, 32'h1);
        cmd_current <= 16'd50;
        cyc(2 * TK);
        check(fl[0], 1);
        wait_fl(0, 1'b0, 6 * TK, n);
        cmd_current <= 16'($urandom % 5);
        wait_fl(1, 1'b1, 6 * TK, n);
        check(n >= 2 * TK, 1);
        cyc(2);
        check(fl[3:2], 2'b00);
        rd(8'h24, 32'h3);
        wr(8'h28, 32'h0);
        cyc(2);
        check(fl[4], 0);
        wr(8'h28, 32'h7);
        cyc(2);
        check(fl[4], 1);
        wr(8'h24, 32'h7);
        cyc(2);
        check(fl[4], 0);
        rd(8'h24, 32'h0);
        cmd_current <= 16'd50;
        wait_fl(1, 1'b0, 5, n);
        wr(8'h08, 32'd9999);
        cmd_current <= hi;
        wait_fl(0, 1'b1, 6 * TK, n);
        cmd_current <= 16'd50;
        wr(8'h0c, 32'h1);
        cyc(12 * TK);
        check(fl[0], 1);
        check(fl[5], 0);
        rd(8'h20, 32'h1);
        cmd_run <= 1'b0;
        cyc(3);
        cmd_run <= 1'b1;
        wait_fl(0, 1'b0, 5, n);
        rd(8'h20, 32'h8);
        cmd_current <= hi;
        wait_fl(0, 1'b1, 6 * TK, n);
        check(fl[5], 1);
        cmd_current <= 16'd50;
        cyc(12 * TK);
        check(fl[5], 1);
        check(fl[0], 1);
        cmd_fault_reset <= 1'b1;
        cyc(1);
        cmd_fault_reset <= 1'b0;
        wait_fl(0, 1'b0, 5, n);
        check(fl[5], 0);
        rd(8'h24, 32'h5);
        cmd_current <= 16'h0;
        wait_fl(1, 1'b1, 6 * TK, n);
        cmd_run <= 1'b0;
        wait_fl(1, 1'b0, 5, n);
        cmd_run <= 1'b1;
        wr(8'h10, 32'h0);
        cmd_current <= 16'h0;
        cyc(6 * TK);
        check(fl[1], 0);
        wr(8'h18, 32'h70);
        wr(8'h1c, 32'hd);
        cyc(2);
        check(fl[3:2], 2'b01);
        end_of_test();
    end
endmodule
`default_nettype wire
